// ---- bench/acs_mem_model.sv ----
// Memory model for the compare-and-swap unit: one 128-bit cell answers every address.
// Assumes the unit holds its request until taken; the bench presets the cell between operations.
`timescale 1ns/1ns
`default_nettype none

module acs_mem_model (
  input  wire logic                  clock_i,     // Clock.
  input  wire logic                  nrst_i,      // Reset, active low.
  input  wire logic                  mem_valid_i, // Request offered.
  output logic                       mem_ready_o, // Request taken.
  input  wire acs_pkg::acs_mem_req_t mem_req_i,   // Request contents.
  output logic                       rsp_valid_o, // Answer pulse.
  output acs_pkg::acs_mem_rsp_t      rsp_o,       // Answer contents.
  input  wire logic                  stall_i,     // Delay acceptance.
  input  wire logic                  fault_i,     // Refuse the access.
  input  wire logic                  load_i,      // Preset the cell.
  input  wire logic [127:0]          load_val_i,  // Preset value.
  output logic [127:0]               cell_o       // Cell contents.
);
  // ****************************************************************
  // Atomic read-modify-write on the cell.
  // ****************************************************************
  logic [127:0] m;
  logic         eq;

  // Lanes of the operand; the rest of the cell keeps its bytes.
  assign m = (mem_req_i.size == acs_pkg::ACS_OP_Q) ? {128{1'b1}} :
             (mem_req_i.size == acs_pkg::ACS_OP_D) ? {64'h0, {64{1'b1}}} : {96'h0, 32'hFFFFFFFF};
  assign eq = ((cell_o ^ mem_req_i.compare_val) & m) == 128'h0;

  // Read, compare and write happen at one edge, so no other writer gets between them.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
      cell_o      <= '0;
    end else begin
      mem_ready_o   <= mem_valid_i && !mem_ready_o && !stall_i;
      rsp_valid_o   <= mem_valid_i && mem_ready_o;
      rsp_o.old_val <= ~rsp_o.old_val; // Stale old_val data is scrambled; stored and fault are held.
      if (load_i) begin
        cell_o <= load_val_i;
      end
      if (mem_valid_i && mem_ready_o) begin
        rsp_o.old_val <= cell_o ^ ~m;
        rsp_o.stored  <= eq && !fault_i;
        rsp_o.fault   <= fault_i;
        if (eq && !fault_i) begin
          cell_o <= (cell_o & ~m) | (mem_req_i.swap_val & m);
        end
      end
    end
  end
endmodule : acs_mem_model
`default_nettype wire

// ---- bench/acs_unit_props.sv ----
// Checker for the compare-and-swap unit: timing and value relations at its ports.
// Assumes it is bound to acs_unit and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"

module acs_unit_props (
  input wire logic                  clock_i,        // Clock.
  input wire logic                  nrst_i,         // Reset, active low.
  input wire logic                  req_valid_i,    // Instruction offered.
  input wire logic                  req_ready_o,    // Unit accepts.
  input wire acs_pkg::acs_req_t     req_i,          // Instruction.
  input wire logic                  mem_valid_o,    // Memory request.
  input wire logic                  mem_ready_i,    // Memory takes it.
  input wire acs_pkg::acs_mem_req_t mem_req_o,      // Request contents.
  input wire logic                  rsp_valid_i,    // Memory answer.
  input wire acs_pkg::acs_mem_rsp_t rsp_i,          // Answer contents.
  input wire logic                  done_o,         // Completion pulse.
  input wire acs_pkg::acs_wb_t      wb_o,           // Writeback.
  input wire acs_pkg::acs_exc_t     exc_o,          // Exception cause.
  input wire logic                  fault_o,        // Access fault.
  input wire logic                  release_done_o  // Release applied.
);
  // ****************************************************************
  // Assertions on the unit's ports.
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Alignment mask of the operand width now requested.
  logic [3:0] amask;
  assign amask = (mem_req_o.size == acs_pkg::ACS_OP_W) ? `ACS_ALIGN_W :
                 (mem_req_o.size == acs_pkg::ACS_OP_D) ? `ACS_ALIGN_D : `ACS_ALIGN_Q;

  // Last instruction taken, so the request fields can be held against it.
  acs_pkg::acs_req_t taken;
  always_ff @(posedge clock_i) begin
    if (req_valid_i && req_ready_o) begin
      taken <= req_i;
    end
  end

  chk_req_fields: assert property (mem_valid_o |-> mem_req_o.address == taken.address &&
      mem_req_o.size == taken.size && mem_req_o.acquire_flag == taken.acquire_flag &&
      mem_req_o.release_flag == taken.release_flag)
    else $error("Memory request fields differ from the instruction.");

  chk_write_perm: assert property (mem_valid_o |-> mem_req_o.write_needed)
    else $error("Write permission not requested.");
  chk_req_hold: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_req_o))
    else $error("Memory request changed before acceptance.");
  chk_one_access: assert property (mem_valid_o && mem_ready_i |=> !mem_valid_o [*2])
    else $error("Second memory access for one instruction.");
  chk_natural_align: assert property (mem_valid_o |-> (mem_req_o.address[3:0] & amask) == 4'h0)
    else $error("Misaligned address sent to memory.");
  chk_done_follows: assert property (rsp_valid_i |=> done_o)
    else $error("No completion after memory answer.");
  chk_fail_norelease: assert property (rsp_valid_i && !rsp_i.stored |=> !release_done_o)
    else $error("Release ordering on failed compare.");
  chk_release_set: assert property (rsp_valid_i && rsp_i.stored && mem_req_o.release_flag |=> release_done_o)
    else $error("Release ordering missing on success.");
  chk_sign_extend: assert property (rsp_valid_i && !rsp_i.fault && mem_req_o.size == acs_pkg::ACS_OP_W |=>
      !wb_o.wr_lo || wb_o.data_lo == {{32{$past(rsp_i.old_val[31])}}, $past(rsp_i.old_val[31:0])})
    else $error("Word result not sign-extended.");
  chk_dword_old: assert property (rsp_valid_i && !rsp_i.fault && mem_req_o.size == acs_pkg::ACS_OP_D |=>
      !wb_o.wr_lo || wb_o.data_lo == $past(rsp_i.old_val[63:0]))
    else $error("Doubleword result differs from memory value.");
  chk_pair_regs: assert property (done_o && wb_o.wr_hi |-> wb_o.reg_lo[0] == 1'b0 && wb_o.reg_lo != 5'h00 &&
      wb_o.reg_hi == (wb_o.reg_lo | 5'h01))
    else $error("Bad destination pair.");
  chk_busy_refuse: assert property (mem_valid_o |-> !req_ready_o)
    else $error("Unit accepts while busy.");

  cov_store: cover property (rsp_valid_i && rsp_i.stored);
  cov_fail: cover property (rsp_valid_i && !rsp_i.stored && !rsp_i.fault);
  cov_reserved: cover property (done_o && exc_o == acs_pkg::ACS_EXC_RESERVED);
  cov_pair: cover property (done_o && wb_o.wr_hi);
endmodule : acs_unit_props

bind acs_unit acs_unit_props u_props (.clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_i(req_i), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
  .mem_req_o(mem_req_o), .rsp_valid_i(rsp_valid_i), .rsp_i(rsp_i), .done_o(done_o), .wb_o(wb_o),
  .exc_o(exc_o), .fault_o(fault_o), .release_done_o(release_done_o));
`default_nettype wire

// ---- bench/tb_atomic_compare_swap_unit.sv ----
// Testbench for the compare-and-swap unit in the 64-bit base, with a memory model.
// Assumes acs_pkg and acs_defs.svh are compiled first; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h vs %h", $time, a, b); end end

module tb_atomic_compare_swap_unit;
  // ****************************************************************
  // Signals, clock and instances.
  // ****************************************************************
  logic                  clock_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0;
  logic                  stall_i = 1'b0, fault_i = 1'b0, load_i = 1'b0;
  logic [127:0]          load_val_i = '0, cell_o;
  acs_pkg::acs_req_t     req_i = '0;
  logic                  req_ready_o, mem_valid_o, mem_ready_i, rsp_valid_i, done_o, fault_o, release_done_o;
  acs_pkg::acs_mem_req_t mem_req_o;
  acs_pkg::acs_mem_rsp_t rsp_i;
  acs_pkg::acs_wb_t      wb_o;
  acs_pkg::acs_exc_t     exc_o;
  int                    error_cnt = 0, check_count = 0;
  logic [31:0]           seed = 32'hDC12748D;

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  acs_unit #(.BASE_64BIT(1'b1)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
    .mem_req_o(mem_req_o), .rsp_valid_i(rsp_valid_i), .rsp_i(rsp_i), .done_o(done_o), .wb_o(wb_o),
    .exc_o(exc_o), .fault_o(fault_o), .release_done_o(release_done_o));
  acs_mem_model u_mem (.clock_i(clock_i), .nrst_i(nrst_i), .mem_valid_i(mem_valid_o), .mem_ready_o(mem_ready_i),
    .mem_req_i(mem_req_o), .rsp_valid_o(rsp_valid_i), .rsp_o(rsp_i), .stall_i(stall_i), .fault_i(fault_i),
    .load_i(load_i), .load_val_i(load_val_i), .cell_o(cell_o));

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : lfsr

  function automatic logic [127:0] r128();
    return {lfsr(), lfsr(), lfsr(), lfsr()};
  endfunction : r128

  // The memory side stalls at random, so acceptance is both prompt and slow.
  always @(negedge clock_i) stall_i <= (lfsr() % 3 == 0);

  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // One instruction: preset the cell, issue, wait for completion, compare with the expectation.
  task automatic op(input acs_pkg::acs_size_t sz, input logic acq, rel, input logic [4:0] rd, rs,
                    input logic [63:0] ad, input logic [127:0] cv, sv, cellv, input logic flt);
    logic [127:0] m, cmpv, swv, expc;
    logic [3:0] am;
    logic eq;
    acs_pkg::acs_exc_t ex;
    int n;
    m = (sz == acs_pkg::ACS_OP_Q) ? {128{1'b1}} : (sz == acs_pkg::ACS_OP_D) ? {64'h0, {64{1'b1}}} : {96'h0, 32'hFFFFFFFF};
    am = (sz == acs_pkg::ACS_OP_W) ? `ACS_ALIGN_W : (sz == acs_pkg::ACS_OP_D) ? `ACS_ALIGN_D : `ACS_ALIGN_Q;
    cmpv = (rd == 5'h00) ? 128'h0 : cv;
    swv = (rs == 5'h00) ? 128'h0 : sv;
    ex = (sz == acs_pkg::ACS_OP_Q && (rd[0] || rs[0])) ? acs_pkg::ACS_EXC_RESERVED :
         ((ad[3:0] & am) != 4'h0) ? acs_pkg::ACS_EXC_MISALIGN : acs_pkg::ACS_EXC_NONE;
    eq = ((cellv ^ cmpv) & m) == 128'h0 && !flt && ex == acs_pkg::ACS_EXC_NONE;
    expc = eq ? ((cellv & ~m) | (swv & m)) : cellv;
    load_val_i = cellv;
    load_i = 1'b1;
    fault_i = flt;
    @(negedge clock_i);
    load_i = 1'b0;
    n = 0;
    while (req_ready_o !== 1'b1) begin
      @(negedge clock_i);
      n++;
      if (n > 50) begin error_cnt++; stop_test(); end
    end
    req_i = '{sz, acq, rel, rd, rs, ad, cv, sv};
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1) begin
      @(negedge clock_i);
      n++;
      if (n > 50) begin error_cnt++; stop_test(); end
    end
    `CHK(exc_o, ex)
    `CHK(cell_o, expc)
    if (ex == acs_pkg::ACS_EXC_NONE) begin
      `CHK(fault_o, flt)
      `CHK(release_done_o, eq && rel)
      `CHK(wb_o.wr_lo, !flt && rd != 5'h00)
      `CHK(wb_o.wr_hi, !flt && rd != 5'h00 && sz == acs_pkg::ACS_OP_Q)
      if (wb_o.wr_lo === 1'b1) begin
        `CHK(wb_o.reg_lo, rd)
        `CHK(wb_o.data_lo, (sz == acs_pkg::ACS_OP_W) ? {{32{cellv[31]}}, cellv[31:0]} : cellv[63:0])
        if (sz == acs_pkg::ACS_OP_Q) `CHK(wb_o.data_hi, cellv[127:64])
      end
    end
  endtask : op

  // ****************************************************************
  // Corner cases first, then random instructions.
  // ****************************************************************
  initial begin
    logic [127:0] c;
    acs_pkg::acs_size_t sz;
    logic [63:0] ad;
    repeat (5) @(negedge clock_i);
    nrst_i = 1'b1;
    c = r128();
    op(acs_pkg::ACS_OP_Q, 1'b1, 1'b1, 5'h00, 5'h02, 64'h40, c, r128(), 128'h0, 1'b0);
    op(acs_pkg::ACS_OP_Q, 1'b0, 1'b1, 5'h04, 5'h00, 64'h50, c, r128(), c, 1'b0);
    op(acs_pkg::ACS_OP_W, 1'b0, 1'b1, 5'h03, 5'h07, 64'h104, {lfsr(), lfsr(), lfsr(), 32'h80000001}, r128(),
       {lfsr(), lfsr(), lfsr(), 32'h80000001}, 1'b0);
    op(acs_pkg::ACS_OP_Q, 1'b0, 1'b0, 5'h03, 5'h02, 64'h60, c, c, c, 1'b0);
    op(acs_pkg::ACS_OP_Q, 1'b0, 1'b0, 5'h02, 5'h04, 64'h68, c, c, c, 1'b0);
    op(acs_pkg::ACS_OP_D, 1'b0, 1'b0, 5'h01, 5'h03, 64'h0C, c, c, c, 1'b0);
    op(acs_pkg::ACS_OP_D, 1'b1, 1'b1, 5'h01, 5'h03, 64'h18, c, r128(), c, 1'b1);
    for (int i = 0; i < 80; i++) begin
      c = r128();
      sz = acs_pkg::acs_size_t'(lfsr() % 3);
      ad = {lfsr(), lfsr()} & ((lfsr() % 8 == 0) ? 64'hFFFFFFFFFFFFFFFF : ~64'hF);
      op(sz, 1'(lfsr()), 1'(lfsr()), 5'(lfsr()), 5'(lfsr()), ad, (lfsr() % 2 == 0) ? c : r128(), r128(), c,
         3'(lfsr()) == 3'h0);
    end
    stop_test();
  end

  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_atomic_compare_swap_unit
`default_nettype wire

// ---- core/acs_operand_fmt.sv ----
// Operand formatter: places compare and swap values in the memory lane layout
// and shapes the old memory value for register writeback.
// Assumes combinational use inside the compare-and-swap unit.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"

module acs_operand_fmt (
  input  wire logic              base_64bit_i,   // High for the 64-bit base.
  input  wire acs_pkg::acs_size_t size_i,        // Operand width.
  input  wire logic [4:0]        dest_reg_i,     // First destination register.
  input  wire logic [4:0]        swap_src_i,     // First swap source register.
  input  wire logic [127:0]      compare_i,      // Destination pair contents.
  input  wire logic [127:0]      swap_i,         // Swap pair contents.
  input  wire logic [127:0]      old_i,          // Value read from memory.
  output logic [127:0]           compare_o,      // Compare value in memory layout.
  output logic [127:0]           swap_o,         // Store value in memory layout.
  output acs_pkg::acs_wb_t       wb_o            // Register writeback.
);

  logic pair_form;
  logic cmp_zero;
  logic swp_zero;
  logic [63:0] cmp_lo;
  logic [63:0] cmp_hi;
  logic [63:0] swp_lo;
  logic [63:0] swp_hi;

  // Pair forms are D in the 32-bit base and Q in either base.
  assign pair_form = (size_i == acs_pkg::ACS_OP_Q) || (!base_64bit_i && size_i == acs_pkg::ACS_OP_D);
  // A source pair starting at the hardwired zero register reads as zero in both halves.
  assign cmp_zero = (dest_reg_i == `ACS_ZERO_REG);
  assign swp_zero = (swap_src_i == `ACS_ZERO_REG);
  assign cmp_lo   = cmp_zero ? 64'h0 : compare_i[63:0];
  assign cmp_hi   = cmp_zero ? 64'h0 : compare_i[127:64];
  assign swp_lo   = swp_zero ? 64'h0 : swap_i[63:0];
  assign swp_hi   = swp_zero ? 64'h0 : swap_i[127:64];

  // Build memory-layout operands; upper bytes beyond the size are zero.
  always_comb begin
    compare_o = 128'h0;
    swap_o    = 128'h0;
    case (size_i)
      acs_pkg::ACS_OP_W: begin
        compare_o[31:0] = cmp_lo[31:0];
        swap_o[31:0]    = swp_lo[31:0];
      end
      acs_pkg::ACS_OP_D: begin
        if (base_64bit_i) begin
          compare_o[63:0] = cmp_lo;
          swap_o[63:0]    = swp_lo;
        end else begin
          compare_o[63:0] = {cmp_hi[31:0], cmp_lo[31:0]};
          swap_o[63:0]    = {swp_hi[31:0], swp_lo[31:0]};
        end
      end
      acs_pkg::ACS_OP_Q: begin
        compare_o = {cmp_hi, cmp_lo};
        swap_o    = {swp_hi, swp_lo};
      end
      default: begin
        compare_o = 128'h0;
        swap_o    = 128'h0;
      end
    endcase
  end

  // Shape the old value for writeback; a pair at the zero register writes nothing.
  always_comb begin
    wb_o        = '0;
    wb_o.reg_lo = dest_reg_i;
    wb_o.reg_hi = dest_reg_i | 5'h01;
    wb_o.wr_lo  = (dest_reg_i != `ACS_ZERO_REG);
    wb_o.wr_hi  = pair_form && (dest_reg_i != `ACS_ZERO_REG);
    case (size_i)
      acs_pkg::ACS_OP_W: begin
        wb_o.data_lo = base_64bit_i ? {{32{old_i[31]}}, old_i[31:0]} : {32'h0, old_i[31:0]};
      end
      acs_pkg::ACS_OP_D: begin
        if (base_64bit_i) begin
          wb_o.data_lo = old_i[63:0];
        end else begin
          wb_o.data_lo = {32'h0, old_i[31:0]};
          wb_o.data_hi = {32'h0, old_i[63:32]};
        end
      end
      acs_pkg::ACS_OP_Q: begin
        wb_o.data_lo = old_i[63:0];
        wb_o.data_hi = old_i[127:64];
      end
      default: begin
        wb_o.wr_lo = 1'b0;
        wb_o.wr_hi = 1'b0;
      end
    endcase
  end

endmodule : acs_operand_fmt

`default_nettype wire

// ---- core/acs_unit.sv ----
// Atomic compare-and-swap execution unit: checks the instruction, issues one
// atomic read-modify-write to memory, and returns the old value to the registers.
// Assumes the memory side holds valid/ready handshakes and keeps the access indivisible.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"

// What this block does
// - 32-bit base word form compares memory with destination, stores swap on equality.
// - The old memory value always returns to the destination, success or failure.
// - 32-bit base doubleword form uses register pairs named register and next.
// - Odd destination or swap register in a pair form is a reserved encoding.
// - A source pair at the hardwired zero register supplies zero in both halves.
// - A destination pair at the hardwired zero register writes no register.
// - 64-bit base word form compares and stores only low 32 bits.
// - 64-bit base word result is sign-extended to register width.
// - 64-bit base doubleword form uses single 64-bit registers, full-width compare.
// - Quadword form exists only in 64-bit base, on 128-bit register pairs.
// - The compare read fetches the whole operand in one atomic access.
// - Address not naturally aligned to 4, 8 or 16 bytes raises an exception.
// - Success carries acquire and release ordering; failure keeps acquire only.
// - A failed compare may skip the write or write back the old value.
// - Write permission is checked on every access, even when the compare fails.
module acs_unit #(
  parameter logic BASE_64BIT = 1'b1                 // High selects the 64-bit base.
) (
  input  wire logic                  clock_i,       // Core clock, 20 MHz.
  input  wire logic                  nrst_i,        // Asynchronous reset, active low.
  input  wire logic                  req_valid_i,   // Instruction offered.
  output logic                       req_ready_o,   // Unit idle and accepting.
  input  wire acs_pkg::acs_req_t     req_i,         // Instruction and operands.
  output logic                       mem_valid_o,   // Atomic request to memory.
  input  wire logic                  mem_ready_i,   // Memory takes the request.
  output acs_pkg::acs_mem_req_t      mem_req_o,     // Atomic request contents.
  input  wire logic                  rsp_valid_i,   // Memory answer present.
  input  wire acs_pkg::acs_mem_rsp_t rsp_i,         // Memory answer contents.
  output logic                       done_o,        // One-cycle completion pulse.
  output acs_pkg::acs_wb_t           wb_o,          // Register writeback, valid with done_o.
  output acs_pkg::acs_exc_t          exc_o,         // Exception cause, valid with done_o.
  output logic                       fault_o,       // Memory access fault, valid with done_o.
  output logic                       release_done_o // Release ordering applied, valid with done_o.
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Alignment mask for the operand size, used only for the misalignment check.
  function automatic logic [3:0] align_mask(input acs_pkg::acs_size_t sz);
    case (sz)
      acs_pkg::ACS_OP_W: align_mask = `ACS_ALIGN_W;
      acs_pkg::ACS_OP_D: align_mask = `ACS_ALIGN_D;
      acs_pkg::ACS_OP_Q: align_mask = `ACS_ALIGN_Q;
      default:           align_mask = `ACS_ALIGN_Q;
    endcase
  endfunction : align_mask

  // Pair forms: doubleword in the 32-bit base, quadword always.
  function automatic logic is_pair(input acs_pkg::acs_size_t sz);
    is_pair = (sz == acs_pkg::ACS_OP_Q) || (!BASE_64BIT && sz == acs_pkg::ACS_OP_D);
  endfunction : is_pair

  typedef enum logic [1:0] {
    ACS_ST_IDLE,
    ACS_ST_ISSUE,
    ACS_ST_WAIT
  } acs_state_t;

  acs_state_t           state;
  acs_pkg::acs_req_t    held;
  acs_pkg::acs_exc_t    next_exc;
  logic [127:0]         fmt_compare;
  logic [127:0]         fmt_swap;
  acs_pkg::acs_wb_t     fmt_wb;
  logic                 take;
  acs_pkg::acs_req_t    cur;

  assign take = req_valid_i && req_ready_o;
  // The instruction being taken is used at once, so the request fields rise together with mem_valid_o.
  assign cur  = take ? req_i : held;

  // ****************************************************************
  // Instruction checks
  // ****************************************************************

  // Reserved encodings win over misalignment; quadword is illegal in the 32-bit base.
  always_comb begin
    next_exc = acs_pkg::ACS_EXC_NONE;
    if (req_i.size == acs_pkg::ACS_OP_Q && !BASE_64BIT) begin
      next_exc = acs_pkg::ACS_EXC_RESERVED;
    end else if (is_pair(req_i.size) && (req_i.dest_reg[0] || req_i.swap_source_reg[0])) begin
      next_exc = acs_pkg::ACS_EXC_RESERVED;
    end else if ((req_i.address[3:0] & align_mask(req_i.size)) != 4'h0) begin
      next_exc = acs_pkg::ACS_EXC_MISALIGN;
    end
  end

  // ****************************************************************
  // Operand formatting
  // ****************************************************************

  acs_operand_fmt u_fmt (
    .base_64bit_i (BASE_64BIT),
    .size_i       (cur.size),
    .dest_reg_i   (cur.dest_reg),
    .swap_src_i   (cur.swap_source_reg),
    .compare_i    (cur.compare_val),
    .swap_i       (cur.swap_val),
    .old_i        (rsp_i.old_val),
    .compare_o    (fmt_compare),
    .swap_o       (fmt_swap),
    .wb_o         (fmt_wb)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Capture the instruction; it stays stable while memory works on it.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held <= '0;
    end else if (take) begin
      held <= req_i;
    end
  end

  // One atomic request per instruction; the unit is idle otherwise.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ACS_ST_IDLE;
    end else begin
      case (state)
        ACS_ST_IDLE: begin
          if (take && next_exc == acs_pkg::ACS_EXC_NONE) begin
            state <= ACS_ST_ISSUE;
          end
        end
        ACS_ST_ISSUE: begin
          if (mem_ready_i) begin
            state <= ACS_ST_WAIT;
          end
        end
        ACS_ST_WAIT: begin
          if (rsp_valid_i) begin
            state <= ACS_ST_IDLE;
          end
        end
        default: state <= ACS_ST_IDLE;
      endcase
    end
  end

  // Ready only while idle and not completing; a new instruction needs one spacer cycle.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state == ACS_ST_IDLE) && !take && !(state == ACS_ST_WAIT && rsp_valid_i);
    end
  end

  // ****************************************************************
  // Memory request
  // ****************************************************************

  // The whole operand goes out as one request; memory must lock the bytes throughout.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_valid_o <= 1'b0;
    end else if (take && next_exc == acs_pkg::ACS_EXC_NONE) begin
      mem_valid_o <= 1'b1;
    end else if (mem_valid_o && mem_ready_i) begin
      mem_valid_o <= 1'b0;
    end
  end

  // Request fields follow the current instruction; they stand unchanged while memory has not taken them.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_req_o <= '0;
    end else begin
      mem_req_o.address      <= cur.address;
      mem_req_o.size         <= cur.size;
      mem_req_o.compare_val  <= fmt_compare;
      mem_req_o.swap_val     <= fmt_swap;
      mem_req_o.write_needed <= 1'b1;
      mem_req_o.acquire_flag <= cur.acquire_flag;
      mem_req_o.release_flag <= cur.release_flag;
    end
  end

  // ****************************************************************
  // Completion
  // ****************************************************************

  // Completion reports the old value, success or not; faults suppress writeback.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o         <= 1'b0;
      wb_o           <= '0;
      exc_o          <= acs_pkg::ACS_EXC_NONE;
      fault_o        <= 1'b0;
      release_done_o <= 1'b0;
    end else begin
      done_o         <= 1'b0;
      wb_o.wr_lo     <= 1'b0;
      wb_o.wr_hi     <= 1'b0;
      release_done_o <= 1'b0;
      fault_o        <= 1'b0;
      exc_o          <= acs_pkg::ACS_EXC_NONE;
      if (take && next_exc != acs_pkg::ACS_EXC_NONE) begin
        done_o <= 1'b1;
        exc_o  <= next_exc;
      end else if (state == ACS_ST_WAIT && rsp_valid_i) begin
        done_o  <= 1'b1;
        fault_o <= rsp_i.fault;
        wb_o    <= fmt_wb;
        if (rsp_i.fault) begin
          wb_o.wr_lo <= 1'b0;
          wb_o.wr_hi <= 1'b0;
        end
        // A failed compare never carries release ordering.
        release_done_o <= held.release_flag && rsp_i.stored;
      end
    end
  end

endmodule : acs_unit

`default_nettype wire

// ---- shared/acs_defs.svh ----
// Constants for the atomic compare-and-swap unit: widths, encodings, alignment masks.
// Assumes it is included by bare name from files that need the numbers.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_XLEN_32      2'h1
`define ACS_XLEN_64      2'h2
`define ACS_SIZE_W       2'h0
`define ACS_SIZE_D       2'h1
`define ACS_SIZE_Q       2'h2
`define ACS_ALIGN_W      4'h3
`define ACS_ALIGN_D      4'h7
`define ACS_ALIGN_Q      4'hF
`define ACS_ZERO_REG     5'h00
`define ACS_WRITE_OLD    1'b0

`endif

// ---- shared/acs_pkg.sv ----
// Types shared by the atomic compare-and-swap unit and its bench.
// Assumes acs_defs.svh is available for constants.
package acs_pkg;

  // Operand width of the instruction.
  typedef enum logic [1:0] {
    ACS_OP_W = 2'h0,
    ACS_OP_D = 2'h1,
    ACS_OP_Q = 2'h2
  } acs_size_t;

  // Instruction issued by the pipeline, operands already read.
  typedef struct packed {
    acs_size_t    size;
    logic         acquire_flag;
    logic         release_flag;
    logic [4:0]   dest_reg;
    logic [4:0]   swap_source_reg;
    logic [63:0]  address;
    logic [127:0] compare_val;   // Destination pair contents, low register in low half.
    logic [127:0] swap_val;      // Swap pair contents, low register in low half.
  } acs_req_t;

  // Atomic read-modify-write request to memory.
  typedef struct packed {
    logic [63:0]  address;
    acs_size_t    size;
    logic [127:0] compare_val;
    logic [127:0] swap_val;
    logic         write_needed;  // Always high: write permission is checked.
    logic         acquire_flag;
    logic         release_flag;  // Release ordering applies only on success.
  } acs_mem_req_t;

  // Memory answer: the old value and whether the store happened.
  typedef struct packed {
    logic [127:0] old_val;
    logic         stored;
    logic         fault;
  } acs_mem_rsp_t;

  // Result to the register file.
  typedef struct packed {
    logic         wr_lo;
    logic         wr_hi;
    logic [4:0]   reg_lo;
    logic [4:0]   reg_hi;
    logic [63:0]  data_lo;
    logic [63:0]  data_hi;
  } acs_wb_t;

  // Exception cause.
  typedef enum logic [1:0] {
    ACS_EXC_NONE     = 2'h0,
    ACS_EXC_MISALIGN = 2'h1,
    ACS_EXC_RESERVED = 2'h2
  } acs_exc_t;

endpackage : acs_pkg
